// ---- amg_pkg.sv ----
// Package for the address mode generator: register codes, mode codes, field positions.
// Assumes a 16-bit core with a 40 MHz clock and an AHB-Lite register port.
package amg_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] AMG_CTRL_OFS   = 8'h00;
    localparam logic [7:0] AMG_INSTR_OFS  = 8'h04;
    localparam logic [7:0] AMG_OPER_OFS   = 8'h08;
    localparam logic [7:0] AMG_IPCS_OFS   = 8'h0C;
    localparam logic [7:0] AMG_EA_OFS     = 8'h10;
    localparam logic [7:0] AMG_OPVAL_OFS  = 8'h14;
    localparam logic [7:0] AMG_BLOCK_OFS  = 8'h18;
    localparam logic [7:0] AMG_GPR_OFS    = 8'h20; // Eight words, 0x20..0x3C
    localparam logic [7:0] AMG_SEG_OFS    = 8'h40; // Four words, 0x40..0x4C
    localparam logic [7:0] AMG_MEM_OFS    = 8'h50; // Memory answer word

    // Control register fields
    localparam int AMG_CTRL_GO_BIT   = 0;
    localparam int AMG_CTRL_STEP_BIT = 1;
    localparam int AMG_CTRL_WORD_BIT = 2;
    localparam int AMG_CTRL_DOWN_BIT = 3;
    localparam int AMG_CTRL_FAR_BIT  = 4;
    localparam int AMG_CTRL_DISP8_BIT = 5;

    // Instruction register fields
    localparam int AMG_MODE_LSB = 0;  // Addressing mode, 4 bits
    localparam int AMG_REG_LSB  = 4;  // gpr_select_field, 3 bits
    localparam int AMG_SREG_LSB = 7;  // segment_select_field, 2 bits
    localparam int AMG_MEM_LSB  = 9;  // operand_loc_field, 3 bits
    localparam int AMG_FORM_LSB = 12; // addr_form_field, 2 bits
    localparam int AMG_LEN_LSB  = 16; // Instruction length, 3 bits

    // Reset values
    localparam logic [15:0] AMG_IP_RST = 16'h0000;
    localparam logic [15:0] AMG_CS_RST = 16'hFFFF;

    // Word register codes in gpr_select_field order
    localparam logic [2:0] AMG_R_ACCUM = 3'h0;
    localparam logic [2:0] AMG_R_COUNT = 3'h1;
    localparam logic [2:0] AMG_R_DATA  = 3'h2;
    localparam logic [2:0] AMG_R_BASEW = 3'h3;
    localparam logic [2:0] AMG_R_STACK = 3'h4;
    localparam logic [2:0] AMG_R_FRAME = 3'h5;
    localparam logic [2:0] AMG_R_SRC   = 3'h6;
    localparam logic [2:0] AMG_R_DST   = 3'h7;

    // Segment codes
    localparam logic [1:0] AMG_S_DATA1 = 2'h0;
    localparam logic [1:0] AMG_S_CODE  = 2'h1;
    localparam logic [1:0] AMG_S_STACK = 2'h2;
    localparam logic [1:0] AMG_S_DATA0 = 2'h3;

    // Addressing modes
    typedef enum logic [3:0] {
        AMG_M_SEQ     = 4'h0,
        AMG_M_DIRECT  = 4'h1,
        AMG_M_REL     = 4'h2,
        AMG_M_REG     = 4'h3,
        AMG_M_REGIND  = 4'h4,
        AMG_M_INDEX   = 4'h5,
        AMG_M_BASED   = 4'h6,
        AMG_M_BASEIDX = 4'h7,
        AMG_M_OPIMM   = 4'h8,
        AMG_M_OPDIR   = 4'h9,
        AMG_M_OPIND   = 4'hA,
        AMG_M_BLOCK   = 4'hB,
        AMG_M_BITFLD  = 4'hC
    } amg_mode_type;

    // Execution states
    typedef enum logic [3:0] {
        AMG_ST_IDLE = 4'b0001,
        AMG_ST_LO   = 4'b0010,
        AMG_ST_HI   = 4'b0100,
        AMG_ST_DONE = 4'b1000
    } amg_state_type;

endpackage : amg_pkg

// ---- amg_address_mode_generator.sv ----
// Address mode generator: branch targets, operand offsets, block stepping.
// Assumes one AHB-Lite master; memory words for indirect branches are supplied by software.
//
// What this block does
// - The pointer steps past each executed instruction unless a branch loads a target.
// - Direct branch loads two or four immediate bytes into pointer, or pointer and segment.
// - Relative branch adds a signed one- or two-byte displacement to the pointer.
// - A one-byte displacement is sign-extended to sixteen bits before the add.
// - The pointer used in the add is the next instruction's first byte.
// - Register branch copies one of eight general words, chosen by three bits.
// - Register-indirect branch reads word or double word at source, dest or base word.
// - Indexed branch adds signed displacement to source or dest index, then fetches.
// - Based branch adds signed displacement to frame base or base word, then fetches.
// - Based-indexed branch sums displacement, base and index, then fetches.
// - Operand register select decodes a three-bit and a two-bit field.
// - Size bit set picks word registers, clear picks byte halves.
// - Segment field picks code, stack, data zero or data one segment.
// - Immediate operand is the instruction constant itself, no memory access.
// - Direct memory operand offset is the sixteen-bit instruction constant.
// - Register-indirect operand offset comes from source, dest or base word.
// - Block and BCD string ops use source index as source, dest index as destination.
// - Bit-field ops use source and dest index as base registers.
// - Block elements step address by one or two, down when the flag is set.
// - Repeated block processing counts remaining elements in the counter word.
`timescale 1ns/1ps

module amg_address_mode_generator
    import amg_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [15:0] eff_addr,
    output logic             eff_addr_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [15:0]   gpr_reg [8];
    logic [15:0]   seg_reg [4];
    logic [15:0]   instr_pointer_reg;
    logic [15:0]   code_segment_reg;
    logic [31:0]   instr_reg;
    logic [31:0]   oper_reg;
    logic [31:0]   mem_reg;
    logic [5:0]    ctrl_reg;
    logic [15:0]   ea_reg;
    logic [15:0]   opval_reg;
    logic          busy_reg;
    amg_state_type state_reg;
    logic          wr_pend_reg;
    logic [7:0]    wr_addr_reg;
    logic          rd_pend_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding functions
    // Byte view of register code: low halves then high halves of four words
    function automatic logic [7:0] byte_view(input logic [2:0] code, input logic [15:0] w0,
                                             input logic [15:0] w1, input logic [15:0] w2,
                                             input logic [15:0] w3);
        logic [15:0] w;
        w = 16'h0000;
        unique case (code[1:0])
            2'h0: w = w0;
            2'h1: w = w1;
            2'h2: w = w2;
            2'h3: w = w3;
        endcase
        return code[2] ? w[15:8] : w[7:0];
    endfunction : byte_view

    // Pointer register for indirect forms: 0 source, 1 dest, else base word
    function automatic logic [15:0] ind_pick(input logic [2:0] sel, input logic [15:0] src,
                                             input logic [15:0] dst, input logic [15:0] bw);
        return (sel == 3'h0) ? src : (sel == 3'h1) ? dst : bw;
    endfunction : ind_pick

    ////////////////////////////////////////////////////////////////////////////
    // Instruction fields
    amg_mode_type mode;
    logic [2:0]   reg_sel;
    logic [1:0]   sreg_sel;
    logic [2:0]   loc_sel;
    logic [1:0]   form_sel;
    logic [2:0]   ilen;
    logic [15:0]  disp16;
    logic [15:0]  imm_lo;
    logic [15:0]  imm_hi;
    logic [15:0]  next_ip;
    logic [15:0]  base_sel;
    logic [15:0]  index_sel;
    logic [15:0]  mem_ea;
    logic [15:0]  step;
    logic [5:0]   ctrl_now;

    assign mode     = amg_mode_type'(instr_reg[AMG_MODE_LSB +: 4]);
    assign reg_sel  = instr_reg[AMG_REG_LSB +: 3];
    assign sreg_sel = instr_reg[AMG_SREG_LSB +: 2];
    assign loc_sel  = instr_reg[AMG_MEM_LSB +: 3];
    assign form_sel = instr_reg[AMG_FORM_LSB +: 2];
    assign ilen     = instr_reg[AMG_LEN_LSB +: 3];
    assign imm_lo   = oper_reg[15:0];
    assign imm_hi   = oper_reg[31:16];

    // Control flags, live during their own write so GO and STEP see their mode bits
    assign ctrl_now = (wr_pend_reg && wr_addr_reg == AMG_CTRL_OFS) ? hwdata[5:0] : ctrl_reg;
    // Displacement, sign-extended when one byte wide
    assign disp16 = ctrl_now[AMG_CTRL_DISP8_BIT] ? {{8{imm_lo[7]}}, imm_lo[7:0]} : imm_lo;
    // Pointer past the current instruction
    assign next_ip = instr_pointer_reg + 16'(ilen);
    // Base and index choices from low field bits
    assign base_sel  = loc_sel[0] ? gpr_reg[AMG_R_BASEW] : gpr_reg[AMG_R_FRAME];
    assign index_sel = loc_sel[1] ? gpr_reg[AMG_R_DST] : gpr_reg[AMG_R_SRC];
    assign step      = ctrl_now[AMG_CTRL_WORD_BIT] ? 16'h0002 : 16'h0001;

    // Memory address for the fetching branch forms and operand forms
    always_comb
    begin
        mem_ea = 16'h0000;
        unique case (mode)
            AMG_M_REGIND, AMG_M_OPIND:
                mem_ea = ind_pick(form_sel == 2'h0 ? loc_sel : 3'h2, gpr_reg[AMG_R_SRC],
                                  gpr_reg[AMG_R_DST], gpr_reg[AMG_R_BASEW]);
            AMG_M_INDEX:   mem_ea = index_sel + disp16;
            AMG_M_BASED:   mem_ea = base_sel + disp16;
            AMG_M_BASEIDX: mem_ea = base_sel + index_sel + disp16;
            AMG_M_OPDIR:   mem_ea = imm_lo;
            AMG_M_BLOCK:   mem_ea = loc_sel[0] ? gpr_reg[AMG_R_DST] : gpr_reg[AMG_R_SRC];
            AMG_M_BITFLD:  mem_ea = loc_sel[0] ? gpr_reg[AMG_R_DST] : gpr_reg[AMG_R_SRC];
            default:       mem_ea = 16'h0000;
        endcase
    end
    logic fetches;
    assign fetches = (mode == AMG_M_REGIND) || (mode == AMG_M_INDEX) ||
                     (mode == AMG_M_BASED) || (mode == AMG_M_BASEIDX);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, writes land on the data phase
    logic addr_ok;
    logic go_wr;
    logic step_wr;
    assign addr_ok   = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign go_wr     = wr_pend_reg && (wr_addr_reg == AMG_CTRL_OFS) && hwdata[AMG_CTRL_GO_BIT];
    assign step_wr   = wr_pend_reg && (wr_addr_reg == AMG_CTRL_OFS) && hwdata[AMG_CTRL_STEP_BIT];

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            if (addr_ok)
                wr_addr_reg <= haddr[7:0];
        end
    end

    // Read data, registered from the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
        begin
            hrdata <= 32'h0000_0000;
            if (haddr[7:0] == AMG_CTRL_OFS)  hrdata <= {busy_reg, 25'h000_0000, ctrl_reg};
            if (haddr[7:0] == AMG_INSTR_OFS) hrdata <= instr_reg;
            if (haddr[7:0] == AMG_OPER_OFS)  hrdata <= oper_reg;
            if (haddr[7:0] == AMG_IPCS_OFS)  hrdata <= {code_segment_reg, instr_pointer_reg};
            if (haddr[7:0] == AMG_EA_OFS)    hrdata <= {16'h0000, ea_reg};
            if (haddr[7:0] == AMG_OPVAL_OFS) hrdata <= {16'h0000, opval_reg};
            if (haddr[7:0] == AMG_MEM_OFS)   hrdata <= mem_reg;
            if (haddr[7:5] == AMG_GPR_OFS[7:5])
                hrdata <= {16'h0000, gpr_reg[haddr[4:2]]};
            if (haddr[7:4] == AMG_SEG_OFS[7:4])
                hrdata <= {16'h0000, (haddr[3:2] == AMG_S_CODE) ? code_segment_reg : seg_reg[haddr[3:2]]};
        end
    end

    // Plain configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            instr_reg <= 32'h0000_0000;
            oper_reg  <= 32'h0000_0000;
            mem_reg   <= 32'h0000_0000;
            ctrl_reg  <= 6'h00;
        end
        else if (wr_pend_reg)
        begin
            if (wr_addr_reg == AMG_INSTR_OFS) instr_reg <= hwdata;
            if (wr_addr_reg == AMG_OPER_OFS)  oper_reg  <= hwdata;
            if (wr_addr_reg == AMG_MEM_OFS)   mem_reg   <= hwdata;
            if (wr_addr_reg == AMG_CTRL_OFS)  ctrl_reg  <= {hwdata[5:2], 2'b00};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: LO waits for software to supply the memory word; HI is never entered
    logic mem_wr;
    assign mem_wr = wr_pend_reg && (wr_addr_reg == AMG_MEM_OFS);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_reg <= AMG_ST_IDLE;
        else
        begin
            unique case (state_reg)
                AMG_ST_IDLE: if (go_wr) state_reg <= fetches ? AMG_ST_LO : AMG_ST_DONE;
                AMG_ST_LO:   if (mem_wr) state_reg <= AMG_ST_DONE;
                AMG_ST_HI:   state_reg <= AMG_ST_DONE;
                AMG_ST_DONE: state_reg <= AMG_ST_IDLE;
                default:     state_reg <= AMG_ST_IDLE;
            endcase
        end
    end
    assign busy_reg = (state_reg != AMG_ST_IDLE);

    // Effective address output
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ea_reg         <= 16'h0000;
            eff_addr       <= 16'h0000;
            eff_addr_valid <= 1'b0;
        end
        else
        begin
            eff_addr_valid <= 1'b0;
            if (state_reg == AMG_ST_IDLE && go_wr)
            begin
                ea_reg         <= mem_ea;
                eff_addr       <= mem_ea;
                eff_addr_valid <= (mode != AMG_M_OPIMM);
            end
        end
    end

    // Operand value: immediate or register view
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            opval_reg <= 16'h0000;
        else if (state_reg == AMG_ST_IDLE && go_wr)
        begin
            if (mode == AMG_M_OPIMM)
                opval_reg <= ctrl_now[AMG_CTRL_WORD_BIT] ? imm_lo : {8'h00, imm_lo[7:0]};
            else if (ctrl_now[AMG_CTRL_FAR_BIT])
                opval_reg <= (sreg_sel == AMG_S_CODE) ? code_segment_reg : seg_reg[sreg_sel];
            else if (ctrl_now[AMG_CTRL_WORD_BIT])
                opval_reg <= gpr_reg[reg_sel];
            else
                opval_reg <= {8'h00, byte_view(reg_sel, gpr_reg[AMG_R_ACCUM], gpr_reg[AMG_R_COUNT],
                                               gpr_reg[AMG_R_DATA], gpr_reg[AMG_R_BASEW])};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction pointer and code segment
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            instr_pointer_reg <= AMG_IP_RST;
            code_segment_reg  <= AMG_CS_RST;
        end
        else if (state_reg == AMG_ST_IDLE && go_wr)
        begin
            unique case (mode)
                AMG_M_DIRECT:
                begin
                    instr_pointer_reg <= imm_lo;
                    if (ctrl_now[AMG_CTRL_FAR_BIT])
                        code_segment_reg <= imm_hi;
                end
                AMG_M_REL:  instr_pointer_reg <= next_ip + disp16;
                AMG_M_REG:  instr_pointer_reg <= gpr_reg[reg_sel];
                AMG_M_REGIND, AMG_M_INDEX, AMG_M_BASED, AMG_M_BASEIDX: instr_pointer_reg <= instr_pointer_reg;
                default:    instr_pointer_reg <= next_ip;
            endcase
        end
        else if (state_reg == AMG_ST_LO && mem_wr)
        begin
            instr_pointer_reg <= hwdata[15:0];
            if (ctrl_now[AMG_CTRL_FAR_BIT])
                code_segment_reg <= hwdata[31:16];
        end
        else if (wr_pend_reg && wr_addr_reg == AMG_SEG_OFS + 8'(4 * AMG_S_CODE))
            code_segment_reg <= hwdata[15:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // General and segment registers, with block stepping
    logic blk_go;
    logic dst_sel;
    assign blk_go  = step_wr && (mode == AMG_M_BLOCK) && (gpr_reg[AMG_R_COUNT] != 16'h0000);
    assign dst_sel = loc_sel[0];
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_gpr
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    gpr_reg[gi] <= 16'h0000;
                else if (wr_pend_reg && wr_addr_reg == AMG_GPR_OFS + 8'(gi * 4))
                    gpr_reg[gi] <= hwdata[15:0];
                else if (blk_go && gi == int'(AMG_R_COUNT))
                    gpr_reg[gi] <= gpr_reg[gi] - 16'h0001;
                else if (blk_go && gi == int'(dst_sel ? AMG_R_DST : AMG_R_SRC))
                    gpr_reg[gi] <= hwdata[AMG_CTRL_DOWN_BIT] ? gpr_reg[gi] - step
                                                             : gpr_reg[gi] + step;
            end
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_seg
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    seg_reg[gi] <= 16'h0000;
                else if (wr_pend_reg && wr_addr_reg == AMG_SEG_OFS + 8'(gi * 4))
                    seg_reg[gi] <= hwdata[15:0];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_rel_target;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == AMG_ST_IDLE && go_wr && mode == AMG_M_REL)
            |=> instr_pointer_reg == $past(next_ip) + $past(disp16);
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("relative target wrong");

    property p_seq_step;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == AMG_ST_IDLE && go_wr && mode == AMG_M_SEQ)
            |=> instr_pointer_reg == $past(instr_pointer_reg) + 16'($past(ilen));
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("pointer did not advance");

    property p_fetch_done;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == AMG_ST_LO && mem_wr) |=> instr_pointer_reg == $past(hwdata[15:0]) ##1 !busy_reg;
    endproperty
    a_fetch_done: assert property (p_fetch_done) else $error("indirect target not loaded");

    property p_count_down;
        @(posedge hclk) disable iff (!hresetn)
        blk_go |=> gpr_reg[AMG_R_COUNT] == $past(gpr_reg[AMG_R_COUNT]) - 16'h0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("block count not decremented");

    property p_imm_noaccess;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == AMG_ST_IDLE && go_wr && mode == AMG_M_OPIMM) |=> !eff_addr_valid;
    endproperty
    a_imm_noaccess: assert property (p_imm_noaccess) else $error("immediate raised access");

    property p_disp_sext;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_now[AMG_CTRL_DISP8_BIT] |-> disp16[15:8] == {8{imm_lo[7]}};
    endproperty
    a_disp_sext: assert property (p_disp_sext) else $error("displacement not sign-extended");

    property p_baseidx;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == AMG_ST_IDLE && go_wr && mode == AMG_M_BASEIDX)
            |=> eff_addr == $past(base_sel) + $past(index_sel) + $past(disp16) ##1 busy_reg;
    endproperty
    a_baseidx: assert property (p_baseidx) else $error("based-indexed address wrong");

    property p_direct_far;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == AMG_ST_IDLE && go_wr && mode == AMG_M_DIRECT && ctrl_now[AMG_CTRL_FAR_BIT])
            |=> code_segment_reg == $past(imm_hi) && instr_pointer_reg == $past(imm_lo);
    endproperty
    a_direct_far: assert property (p_direct_far) else $error("far direct target wrong");

endmodule : amg_address_mode_generator

// ---- amg_mem_model.sv ----
// Memory model for the far side: word and double-word answers for indirect branches.
// Assumes the bench hands it the effective address and copies the answer into the memory word register.
`timescale 1ns/1ps

module amg_mem_model
(
    input  wire logic [15:0] addr,
    output logic      [31:0] rdata
);
    // Content tied to the address, so a wrong address gives a wrong target
    always_comb rdata = {addr ^ 16'hA5A5, addr + 16'h0400};
endmodule : amg_mem_model

// ---- tb_top.sv ----
// Testbench for the address mode generator: AHB-Lite tasks and directed branch and operand tests.
// Assumes one AHB-Lite slave with hready looped from hreadyout, and the memory model on the far side.
`timescale 1ns/1ps

module tb_top
    import amg_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, eff_addr_valid;
    logic [31:0] haddr, hwdata, hrdata, rd, mem_word;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] eff_addr, last_ea;
    int          n_errors, checks_done, cycles;

    amg_address_mode_generator u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .eff_addr(eff_addr), .eff_addr_valid(eff_addr_valid));
    amg_mem_model u_mem (.addr(last_ea), .rdata(mem_word));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // Hang guard and capture of the address handed to the bus unit
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (eff_addr_valid === 1'b1)
            last_ea <= eff_addr;
        if (cycles == 20000)
        begin
            n_errors++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One single AHB-Lite word transfer; read data lands in rd
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask : rchk

    // Load instruction and operand, then start
    task automatic go(input logic [31:0] instr, input logic [31:0] oper, input logic [31:0] ctrl);
        xfer(1'b1, AMG_INSTR_OFS, instr);
        xfer(1'b1, AMG_OPER_OFS, oper);
        xfer(1'b1, AMG_CTRL_OFS, ctrl);
        repeat (3) @(posedge hclk);
    endtask : go

    // Fetch modes: check the address, answer from memory, wait out busy
    task automatic fetch(input logic [31:0] instr, input logic [31:0] oper, input logic [31:0] ctrl,
                         input logic [15:0] ea);
        go(instr, oper, ctrl);
        chk({16'h0000, last_ea}, {16'h0000, ea});
        xfer(1'b1, AMG_MEM_OFS, mem_word);
        repeat (3) @(posedge hclk);
        xfer(1'b0, AMG_CTRL_OFS, 32'h0000_0000);
        chk({31'h0000_0000, rd[31]}, 32'h0000_0000);
    endtask : fetch

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        n_errors    = 0;
        checks_done = 0;
        cycles      = 0;
        last_ea     = 16'h0000;
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0000_0000;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hsize       = 3'h2;
        hwdata      = 32'h0000_0000;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(AMG_IPCS_OFS, 32'hFFFF_0000);
        rchk(8'hFC, 32'h0000_0000);
        go(32'h0003_0000, 32'h0000_0000, 32'h0000_0001);
        rchk(AMG_IPCS_OFS, 32'hFFFF_0003);
        go(32'h0002_0002, 32'h0000_00F0, 32'h0000_0021);
        rchk(AMG_IPCS_OFS, 32'hFFFF_FFF5);
        go(32'h0003_0002, 32'h0000_0100, 32'h0000_0001);
        rchk(AMG_IPCS_OFS, 32'hFFFF_00F8);
        go(32'h0000_0001, 32'h1234_5678, 32'h0000_0011);
        rchk(AMG_IPCS_OFS, 32'h1234_5678);
        rchk(AMG_SEG_OFS + 8'h04, 32'h0000_1234);
        // Every general word as a branch target
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, AMG_GPR_OFS + 8'(4 * i), 32'h0000_1000 + 32'(i));
            go(32'h0000_0003 | 32'(i << 4), 32'h0000_0000, 32'h0000_0001);
            rchk(AMG_IPCS_OFS, 32'h1234_1000 + 32'(i));
        end
        xfer(1'b1, AMG_GPR_OFS + 8'h18, 32'h0000_0100);
        fetch(32'h0000_0005, 32'h0000_FFF0, 32'h0000_0011, 16'h00F0);
        rchk(AMG_IPCS_OFS, 32'hA555_04F0);
        fetch(32'h0000_0207, 32'h0000_0002, 32'h0000_0001, 16'h1105);
        rchk(AMG_IPCS_OFS, 32'hA555_1505);
        fetch(32'h0000_0204, 32'h0000_0000, 32'h0000_0001, 16'h1007);
        rchk(AMG_IPCS_OFS, 32'hA555_1407);
        fetch(32'h0000_0006, 32'h0000_0080, 32'h0000_0021, 16'h0F85);
        rchk(AMG_IPCS_OFS, 32'hA555_1385);
        go(32'h0000_0009, 32'h0000_BEEF, 32'h0000_0001);
        chk({16'h0000, last_ea}, 32'h0000_BEEF);
        go(32'h0000_0008, 32'h0000_00A5, 32'h0000_0001);
        rchk(AMG_OPVAL_OFS, 32'h0000_00A5);
        chk({16'h0000, last_ea}, 32'h0000_BEEF);
        go(32'h0000_000A, 32'h0000_0000, 32'h0000_0001);
        chk({16'h0000, last_ea}, 32'h0000_0100);
        // Block stepping: word up, byte down, then a spent counter
        xfer(1'b1, AMG_GPR_OFS + 8'h04, 32'h0000_0002);
        xfer(1'b1, AMG_GPR_OFS + 8'h18, 32'h0000_0010);
        xfer(1'b1, AMG_INSTR_OFS, 32'h0000_000B);
        xfer(1'b1, AMG_CTRL_OFS, 32'h0000_0006);
        rchk(AMG_GPR_OFS + 8'h18, 32'h0000_0012);
        rchk(AMG_GPR_OFS + 8'h04, 32'h0000_0001);
        xfer(1'b1, AMG_CTRL_OFS, 32'h0000_000A);
        rchk(AMG_GPR_OFS + 8'h18, 32'h0000_0011);
        xfer(1'b1, AMG_CTRL_OFS, 32'h0000_0006);
        rchk(AMG_GPR_OFS + 8'h18, 32'h0000_0011);
        xfer(1'b1, AMG_GPR_OFS + 8'h04, 32'h0000_0001);
        xfer(1'b1, AMG_INSTR_OFS, 32'h0000_020B);
        xfer(1'b1, AMG_CTRL_OFS, 32'h0000_0006);
        rchk(AMG_GPR_OFS + 8'h1C, 32'h0000_1009);
        // Bit-field base, then byte, word and segment operand views
        go(32'h0000_020C, 32'h0000_0000, 32'h0000_0001);
        chk({16'h0000, last_ea}, 32'h0000_1009);
        go(32'h0000_0030, 32'h0000_0000, 32'h0000_0001);
        rchk(AMG_OPVAL_OFS, 32'h0000_0003);
        go(32'h0000_0050, 32'h0000_0000, 32'h0000_0005);
        rchk(AMG_OPVAL_OFS, 32'h0000_1005);
        go(32'h0000_0080, 32'h0000_0000, 32'h0000_0011);
        rchk(AMG_OPVAL_OFS, 32'h0000_A555);
        summarize();
    end
endmodule : tb_top
